// ### rtc_i2c_pkg.sv
package rtc_i2c_pkg;

  // Clock rate of the block and the transaction time limit.
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned TIMEOUT_S   = 1;
  localparam int unsigned TIMEOUT_CYC = CLK_HZ * TIMEOUT_S;

  // Fixed 7-bit slave address; the full byte is this plus the direction bit.
  localparam logic [6:0] SLAVE_ADDR = 7'h32;
  localparam logic       DIR_READ   = 1'h1;

  // Bit counting within one byte.
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [2:0] LAST_BIT   = 3'h7;

  // Register pointer reset value and step.
  localparam logic [7:0] PTR_RST    = 8'h00;
  localparam logic [7:0] PTR_STEP   = 8'h01;

  // Byte value seen by the master while the device keeps SDA released.
  localparam logic [7:0] IDLE_BYTE  = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_IGNORE
  } port_state_t;

  // One register write handed to the register file.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_word_t;

endpackage

// ### wr_skid_buffer.sv
module wr_skid_buffer (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  in_valid_i,
  output logic                       in_ready_o,
  input  wire rtc_i2c_pkg::wr_word_t in_word_i,
  output logic                       out_valid_o,
  input  wire logic                  out_ready_i,
  output rtc_i2c_pkg::wr_word_t      out_word_o
);

  logic                  out_valid_ff;
  logic                  spare_valid_ff;
  rtc_i2c_pkg::wr_word_t out_word_ff;
  rtc_i2c_pkg::wr_word_t spare_word_ff;
  logic                  push;
  logic                  pop;

  // Ready only depends on the spare slot, so it is a clean register term.
  assign in_ready_o  = ~spare_valid_ff;
  assign out_valid_o = out_valid_ff;
  assign out_word_o  = out_word_ff;
  assign push        = in_valid_i & ~spare_valid_ff;
  assign pop         = out_valid_ff & out_ready_i;

  // The head slot feeds the output; the spare catches a word during a stall.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_ff   <= 1'b0;
      spare_valid_ff <= 1'b0;
      out_word_ff    <= '0;
      spare_word_ff  <= '0;
    end else if (pop) begin
      if (spare_valid_ff) begin
        out_word_ff    <= spare_word_ff;
        spare_valid_ff <= 1'b0;
      end else if (push) begin
        out_word_ff <= in_word_i;
      end else begin
        out_valid_ff <= 1'b0;
      end
    end else if (push) begin
      if (!out_valid_ff) begin
        out_word_ff  <= in_word_i;
        out_valid_ff <= 1'b1;
      end else begin
        spare_word_ff  <= in_word_i;
        spare_valid_ff <= 1'b1;
      end
    end
  end

endmodule

// ### rtc_i2c_slave_port.sv
// Contract
// - Both lines rest high when bus idle
// - SDA falling while SCL high starts
// - SDA rising while SCL high stops
// - Second START restarts address decoding
// - STOP accepted anywhere while receiving
// - One second busy clears interface to idle
// - After timeout writes dropped, reads all-ones
// - Resume only on a fresh START
// - Unlimited bytes of eight bits each
// - Change SDA on low SCL, sample high
// - SDA change during high SCL is condition
// - Receiver drives ninth clock low as ACK
// - Release SDA at end of ninth clock
// - Master NACK: release SDA, await STOP
// - Missing ACK means byte not accepted
// - Respond only to own fixed address
// - Direction bit is LSB, 65h/64h
// - First write byte sets pointer, then increments
// - Pointer write, repeated START, read from pointer
// - Direct read starts after last accessed
// - Clock values frozen while transaction active
module rtc_i2c_slave_port #(
  parameter int unsigned TIMEOUT_CYCLES = rtc_i2c_pkg::TIMEOUT_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  output logic [7:0]                 rd_addr_o,
  input  wire logic [7:0]            rd_data_i,
  output logic                       wr_valid_o,
  input  wire logic                  wr_ready_i,
  output rtc_i2c_pkg::wr_word_t      wr_word_o,
  output logic                       busy_o,
  output logic                       timeout_o
);

  logic                     scl_m_ff;
  logic                     scl_s_ff;
  logic                     scl_d_ff;
  logic                     sda_m_ff;
  logic                     sda_s_ff;
  logic                     sda_d_ff;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_det;
  logic                     stop_det;
  rtc_i2c_pkg::port_state_t state_ff;
  logic [3:0]               bit_cnt_ff;
  logic [7:0]               rx_shift_ff;
  logic [7:0]               tx_shift_ff;
  logic [7:0]               ptr_ff;
  logic                     ptr_pend_ff;
  logic                     oe_ff;
  logic                     sda_drv_ff;
  logic                     busy_ff;
  logic                     timeout_ff;
  logic [31:0]              tmo_cnt_ff;
  logic                     tmo_hit;
  logic                     buf_ready;
  logic                     push_ff;
  rtc_i2c_pkg::wr_word_t    push_word_ff;
  logic                     addr_match;

  // Three flip-flops per bus line; only the second stage and later are read.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_i;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= sda_i;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  // Edges of SCL and bus conditions; an SDA edge under high SCL is never data.
  assign scl_rise  = scl_s_ff & ~scl_d_ff;
  assign scl_fall  = ~scl_s_ff & scl_d_ff;
  assign start_det = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  assign stop_det  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

  // The top seven bits of the address byte must equal the fixed address.
  assign addr_match = (rx_shift_ff[7:1] == rtc_i2c_pkg::SLAVE_ADDR);

  // The transaction timer counts from the first START, not from a restart.
  assign tmo_hit = busy_ff & (tmo_cnt_ff == 32'(TIMEOUT_CYCLES - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmo_cnt_ff <= '0;
    end else if (!busy_ff || tmo_hit) begin
      tmo_cnt_ff <= '0;
    end else begin
      tmo_cnt_ff <= tmo_cnt_ff + 32'h0000_0001;
    end
  end

  // Busy marks an open transaction so the clock counters hold their carry.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_ff    <= 1'b0;
      timeout_ff <= 1'b0;
    end else begin
      timeout_ff <= tmo_hit;
      if (stop_det || tmo_hit) begin
        busy_ff <= 1'b0;
      end else if (start_det) begin
        busy_ff <= 1'b1;
      end
    end
  end

  // Main byte engine. SDA is only changed right after a falling SCL edge, except for its release on a timeout.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff    <= rtc_i2c_pkg::ST_IDLE;
      bit_cnt_ff  <= '0;
      rx_shift_ff <= '0;
      tx_shift_ff <= rtc_i2c_pkg::IDLE_BYTE;
      ptr_ff      <= rtc_i2c_pkg::PTR_RST;
      ptr_pend_ff <= 1'b0;
      oe_ff       <= 1'b0;
      push_ff     <= 1'b0;
      push_word_ff <= '0;
    end else begin
      push_ff <= 1'b0;
      if (tmo_hit) begin
        // Later bytes find an idle port: writes drop, reads see ones.
        state_ff <= rtc_i2c_pkg::ST_IDLE;
        oe_ff    <= 1'b0;
      end else if (start_det) begin
        // Also a repeated START: address decoding begins again.
        state_ff   <= rtc_i2c_pkg::ST_ADDR;
        bit_cnt_ff <= '0;
        oe_ff      <= 1'b0;
      end else if (stop_det) begin
        state_ff <= rtc_i2c_pkg::ST_IDLE;
        oe_ff    <= 1'b0;
      end else begin
        case (state_ff)
          rtc_i2c_pkg::ST_ADDR,
          rtc_i2c_pkg::ST_RX: begin
            if (scl_rise && bit_cnt_ff != rtc_i2c_pkg::BYTE_BITS) begin
              // Sampled on high SCL, most significant bit first.
              rx_shift_ff <= {rx_shift_ff[6:0], sda_s_ff};
              bit_cnt_ff  <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == rtc_i2c_pkg::BYTE_BITS) begin
              if (state_ff == rtc_i2c_pkg::ST_ADDR) begin
                if (addr_match) begin
                  oe_ff    <= 1'b1;
                  state_ff <= rtc_i2c_pkg::ST_ADDR_ACK;
                end else begin
                  state_ff <= rtc_i2c_pkg::ST_IGNORE;
                end
              end else if (ptr_pend_ff) begin
                ptr_ff      <= rx_shift_ff;
                ptr_pend_ff <= 1'b0;
                oe_ff       <= 1'b1;
                state_ff    <= rtc_i2c_pkg::ST_RX_ACK;
              end else begin
                // A full buffer refuses the byte with a NACK, so no loss.
                if (buf_ready) begin
                  push_ff      <= 1'b1;
                  push_word_ff <= '{addr: ptr_ff, data: rx_shift_ff};
                  ptr_ff       <= ptr_ff + rtc_i2c_pkg::PTR_STEP;
                  oe_ff        <= 1'b1;
                end
                state_ff <= rtc_i2c_pkg::ST_RX_ACK;
              end
            end
          end
          rtc_i2c_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt_ff <= '0;
              if (rx_shift_ff[0] == rtc_i2c_pkg::DIR_READ) begin
                // Read with no pointer write continues after the last one.
                tx_shift_ff <= rd_data_i;
                oe_ff       <= ~rd_data_i[7];
                ptr_ff      <= ptr_ff + rtc_i2c_pkg::PTR_STEP;
                state_ff    <= rtc_i2c_pkg::ST_TX;
              end else begin
                oe_ff       <= 1'b0;
                ptr_pend_ff <= 1'b1;
                state_ff    <= rtc_i2c_pkg::ST_RX;
              end
            end
          end
          rtc_i2c_pkg::ST_RX_ACK: begin
            if (scl_fall) begin
              oe_ff      <= 1'b0;
              bit_cnt_ff <= '0;
              state_ff   <= rtc_i2c_pkg::ST_RX;
            end
          end
          rtc_i2c_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_ff[2:0] == rtc_i2c_pkg::LAST_BIT) begin
                oe_ff    <= 1'b0;
                state_ff <= rtc_i2c_pkg::ST_TX_ACK;
              end else begin
                tx_shift_ff <= {tx_shift_ff[6:0], 1'b1};
                oe_ff       <= ~tx_shift_ff[6];
                bit_cnt_ff  <= bit_cnt_ff + 4'h1;
              end
            end
          end
          rtc_i2c_pkg::ST_TX_ACK: begin
            if (scl_rise) begin
              // Remember the master's answer in the spare counter bit.
              bit_cnt_ff[3] <= sda_s_ff;
            end else if (scl_fall) begin
              bit_cnt_ff <= '0;
              if (!bit_cnt_ff[3]) begin
                tx_shift_ff <= rd_data_i;
                oe_ff       <= ~rd_data_i[7];
                ptr_ff      <= ptr_ff + rtc_i2c_pkg::PTR_STEP;
                state_ff    <= rtc_i2c_pkg::ST_TX;
              end else begin
                oe_ff    <= 1'b0;
                state_ff <= rtc_i2c_pkg::ST_IGNORE;
              end
            end
          end
          rtc_i2c_pkg::ST_IGNORE: begin
            oe_ff <= 1'b0;
          end
          default: begin
            oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // The pad only ever pulls low; the enable carries the bit value.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_drv_ff <= 1'b0;
    end else begin
      sda_drv_ff <= 1'b0;
    end
  end

  assign sda_o     = sda_drv_ff;
  assign sda_oe_o  = oe_ff;
  assign rd_addr_o = ptr_ff;
  assign busy_o    = busy_ff;
  assign timeout_o = timeout_ff;

  // Writes pass through a two-entry buffer toward the register file.
  wr_skid_buffer u_wr_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_ff),
    .in_ready_o  (buf_ready),
    .in_word_i   (push_word_ff),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_word_o  (wr_word_o)
  );

endmodule

// ### rtc_i2c_port_monitor.sv
module rtc_i2c_port_monitor #(
  parameter int unsigned TIMEOUT_CYCLES = 2000
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  scl_i,
  input wire logic                  sda_i,
  input wire logic                  sda_oe_o,
  input wire logic                  wr_valid_o,
  input wire logic                  wr_ready_i,
  input wire rtc_i2c_pkg::wr_word_t wr_word_o,
  input wire logic                  busy_o,
  input wire logic                  timeout_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [31:0] busy_cnt_ff;

  // Counts busy cycles, so a timer that never fires shows as an overrun.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      busy_cnt_ff <= 32'h0;
    else
      busy_cnt_ff <= busy_o ? busy_cnt_ff + 32'h1 : 32'h0;
  end

  // START and STOP relations are loose by a few cycles to cover the input sync.
  idle_release_a: assert property (!busy_o |-> !sda_oe_o)
    else $error("SDA driven while idle");
  start_busy_a: assert property (
    $fell(sda_i) && scl_i |-> ##[1:6] busy_o)
    else $error("START not seen");
  stop_idle_a: assert property (
    $rose(sda_i) && scl_i |-> ##[1:6] !busy_o)
    else $error("STOP not seen");
  oe_low_scl_a: assert property (
    $changed(sda_oe_o) && busy_o |-> !scl_i)
    else $error("SDA moved while SCL high");
  busy_limit_a: assert property (
    busy_o |-> busy_cnt_ff <= TIMEOUT_CYCLES)
    else $error("Transaction outlived the timer");
  // The pulse rides on the first idle cycle after the clear.
  timeout_gap_a: assert property (
    timeout_o |-> !busy_o && $past(busy_o))
    else $error("Timeout pulse not at clear");
  timeout_quiet_a: assert property (timeout_o |-> !sda_oe_o [*8])
    else $error("SDA driven after timeout");
  word_hold_a: assert property (
    wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_word_o))
    else $error("Write word lost while stalled");

  cover property (wr_valid_o && !wr_ready_i);
  cover property (timeout_o);
  cover property ($rose(sda_oe_o) && busy_o);
endmodule

bind rtc_i2c_slave_port rtc_i2c_port_monitor #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) mon (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_oe_o(sda_oe_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
  .wr_word_o(wr_word_o), .busy_o(busy_o), .timeout_o(timeout_o)
);

// ### i2c_master_model.sv
module i2c_master_model (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus rests released; the pull-up holds both lines high.
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // One 32 ns SCL period, 16 ns low and 16 ns high. SDA moves 4 ns into
  // the low phase; the slave answers about 10 ns after the fall, which
  // still leaves one system clock before SCL rises again.
  task automatic bit_cell(input logic b, output logic r);
    #4 sda_oe_o = ~b;
    #12 scl_o = 1'b1;
    #8 r = sda_i;
    #8 scl_o = 1'b0;
  endtask

  // Only this model makes START and repeated START.
  task automatic start_c();
    #16 sda_oe_o = 1'b0;
    #16 scl_o = 1'b1;
    #16 sda_oe_o = 1'b1;
    #16 scl_o = 1'b0;
  endtask

  // STOP leaves both lines released and closes the transaction in time.
  task automatic stop_c();
    #16 sda_oe_o = 1'b1;
    #32 scl_o = 1'b1;
    #16 sda_oe_o = 1'b0;
    #16;
  endtask

  // Byte out MSB first, then SDA released for the ninth clock.
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cell(b[i], r);
    bit_cell(1'b1, r);
    ack = ~r;
  endtask

  // Byte in, then acknowledge or a deliberate NACK.
  task automatic recv(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cell(1'b1, d[i]);
    bit_cell(nack, r);
  endtask
endmodule

// ### rtc_i2c_slave_port_tb.sv
module rtc_i2c_slave_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TO_CYC = 2000;
  logic                  clk_i, rst_i, wr_ready_i, scl, m_oe, sda_line;
  logic                  sda_oe, sda_o, wr_valid, busy, tmo;
  logic [7:0]            rd_addr, rd_data;
  logic [7:0]            regs [0:255] = '{default: 8'h00};
  rtc_i2c_pkg::wr_word_t wr_word;
  int                    fail_count, num_checks;

  // Open-drain wire with pull-up: an enabled driver shows its drive value,
  // so a wrong drive level from the port turns every acknowledge into NACK.
  assign sda_line = (sda_oe ? sda_o : 1'b1) & ~m_oe;
  assign rd_data = regs[rd_addr];
  always @(posedge clk_i) if (wr_valid & wr_ready_i) regs[wr_word.addr] <= wr_word.data;

  rtc_i2c_slave_port #(.TIMEOUT_CYCLES(TO_CYC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready_i),
    .wr_word_o(wr_word), .busy_o(busy), .timeout_o(tmo));
  i2c_master_model mst (.sda_i(sda_line), .scl_o(scl), .sda_oe_o(m_oe));

  // Free-running 250 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bounded wait for idle, or for the timeout pulse.
  task automatic wait_for(input bit want_tmo, input int n);
    for (int i = 0; i < n; i++) begin
      if (want_tmo ? tmo === 1'b1 : busy === 1'b0) return;
      @(negedge clk_i);
    end
    fail_count++;
    test_done();
  endtask

  task automatic wr_byte(input logic [7:0] b, input logic exp_ack);
    logic a;
    mst.send(b, a);
    check("ack", {7'h00, exp_ack}, {7'h00, a});
  endtask

  task automatic rd_byte(input logic nack, input logic [7:0] exp);
    logic [7:0] d;
    mst.recv(nack, d);
    check("read byte", exp, d);
  endtask

  task automatic t_write();
    mst.start_c();
    wr_byte(8'h64, 1'b1);
    wr_byte(8'h10, 1'b1);
    wr_byte(8'hA5, 1'b1);
    wr_byte(8'h3C, 1'b1);
    wr_byte(8'h96, 1'b1);
    wr_byte(8'h5A, 1'b1);
    mst.stop_c();
    wait_for(1'b0, 50);
    check("reg 10", 8'hA5, regs[8'h10]);
    check("reg 13", 8'h5A, regs[8'h13]);
  endtask

  task automatic t_read_ptr();
    mst.start_c();
    wr_byte(8'h64, 1'b1);
    wr_byte(8'h10, 1'b1);
    mst.start_c();
    wr_byte(8'h65, 1'b1);
    rd_byte(1'b0, 8'hA5);
    rd_byte(1'b0, 8'h3C);
    rd_byte(1'b1, 8'h96);
    mst.stop_c();
    wait_for(1'b0, 50);
    mst.start_c();
    wr_byte(8'h65, 1'b1);
    rd_byte(1'b1, 8'h5A);
    mst.stop_c();
    wait_for(1'b0, 50);
  endtask

  task automatic t_foreign();
    mst.start_c();
    wr_byte(8'h66, 1'b0);
    wr_byte(8'h64, 1'b0);
    mst.stop_c();
    wait_for(1'b0, 50);
  endtask

  // Stalled register file: two words buffered, third byte refused.
  task automatic t_full();
    wr_ready_i = 1'b0;
    mst.start_c();
    wr_byte(8'h64, 1'b1);
    wr_byte(8'h20, 1'b1);
    wr_byte(8'h11, 1'b1);
    wr_byte(8'h22, 1'b1);
    wr_byte(8'h33, 1'b0);
    mst.stop_c();
    wait_for(1'b0, 50);
    check("stalled valid", 8'h01, {7'h00, wr_valid});
    wr_ready_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("reg 20", 8'h11, regs[8'h20]);
    check("reg 21", 8'h22, regs[8'h21]);
    check("reg 22", 8'h00, regs[8'h22]);
    check("drained", 8'h00, {7'h00, wr_valid});
  endtask

  // STOP in the middle of a received byte; the pointer is left on a word
  // with a known nonzero value for the later direct read.
  task automatic t_abort();
    logic r;
    mst.start_c();
    wr_byte(8'h64, 1'b1);
    wr_byte(8'h12, 1'b1);
    for (int i = 0; i < 3; i++) mst.bit_cell(1'b1, r);
    mst.stop_c();
    wait_for(1'b0, 50);
    repeat (4) @(negedge clk_i);
    check("no write", 8'h00, {7'h00, wr_valid});
    check("reg 12 kept", 8'h96, regs[8'h12]);
  endtask

  // Timeout mid-write; bytes after it are ignored until a fresh START.
  task automatic t_timeout();
    mst.start_c();
    wr_byte(8'h64, 1'b1);
    wait_for(1'b1, TO_CYC + 200);
    check("busy cleared", 8'h00, {7'h00, busy});
    wr_byte(8'h40, 1'b0);
    rd_byte(1'b1, rtc_i2c_pkg::IDLE_BYTE);
    mst.start_c();
    wr_byte(8'h65, 1'b1);
    rd_byte(1'b1, 8'h96);
    mst.stop_c();
    wait_for(1'b0, 50);
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    rst_i = 1'b1;
    wr_ready_i = 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    check("reset ptr", 8'h00, rd_addr);
    check("sda drive", 8'h00, {7'h00, sda_o});
    repeat (4) @(negedge clk_i);
    t_write();
    t_read_ptr();
    t_foreign();
    t_full();
    t_abort();
    t_timeout();
    test_done();
  end
endmodule
